// [core/scs_core.sv]
// Purpose: spi configuration register, status flags and serial engine
// Assumes: control and data registers live elsewhere and drive the side ports
// Notes: all pins are sampled on clk through two flops

module scs_core #(
  parameter int DATA_BITS = scs_pkg::BYTE_BITS,
  parameter int HALF_CYCLES = scs_pkg::SCK_HALF_CYCLES,
  parameter int FILTER_CYCLES = scs_pkg::SELECT_FILTER_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // from the control and data registers
  input wire logic spi_enable,
  input wire logic four_wire,
  input wire logic tx_load,
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic rx_read,
  output logic tx_empty,
  output logic [DATA_BITS-1:0] rx_data,
  output logic byte_done_flag,
  // serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic select_n_in
);

  localparam int CW = $clog2(DATA_BITS + 1);
  localparam logic [CW-1:0] LAST_BIT = CW'(DATA_BITS - 1);
  localparam logic [7:0] HALF_END = 8'(HALF_CYCLES - 1);
  localparam logic [3:0] FILT_END = 4'(FILTER_CYCLES - 1);

  // ----------------------------------------
  // pin synchronisers and select filter
  // ----------------------------------------
  logic [3:0] pin_sync;
  logic sck_s, mosi_s, miso_s, sel_raw;
  logic sel_filt, sel_prev, sel_fall;
  logic [3:0] filt_cnt;

  scs_sync #(.WIDTH(4), .RESET_VAL(4'h8)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({select_n_in, miso_in, mosi_in, sck_in}),
    .sync_out(pin_sync)
  );

  assign sck_s = pin_sync[0];
  assign mosi_s = pin_sync[1];
  assign miso_s = pin_sync[2];
  assign sel_raw = pin_sync[3];

  // a new select level must persist before it is believed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_filt <= 1'b1;
      filt_cnt <= 4'h0;
    end else if (clk_en) begin
      if (sel_raw == sel_filt) begin
        filt_cnt <= 4'h0;
      end else if (filt_cnt == FILT_END) begin
        sel_filt <= sel_raw;
        filt_cnt <= 4'h0;
      end else begin
        filt_cnt <= filt_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_prev <= 1'b1;
    end else if (clk_en) begin
      sel_prev <= sel_filt;
    end
  end

  assign sel_fall = sel_prev & ~sel_filt;

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  logic master_select, clock_phase_select, clock_polarity_select;
  logic cfg_hit;

  assign cfg_hit = sfr_addr == scs_pkg::CFG_ADDR;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      master_select <= scs_pkg::MASTER_RST;
      clock_phase_select <= scs_pkg::PHASE_RST;
      clock_polarity_select <= scs_pkg::POL_RST;
    end else if (clk_en && sfr_wr && cfg_hit) begin
      // status bits have no storage here, so writes to them vanish
      master_select <= sfr_wdata[scs_pkg::BIT_MASTER];
      clock_phase_select <= sfr_wdata[scs_pkg::BIT_PHASE];
      clock_polarity_select <= sfr_wdata[scs_pkg::BIT_POL];
    end
  end

  // ----------------------------------------
  // slave edge detection
  // ----------------------------------------
  logic sck_prev, sck_edge, sck_lead, sck_trail;
  logic slave_active, slave_sample, slave_shift, slave_busy;
  logic [CW-1:0] bit_cnt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_prev <= 1'b0;
    end else if (clk_en) begin
      sck_prev <= sck_s;
    end
  end

  assign sck_edge = sck_s ^ sck_prev;
  assign sck_lead = sck_edge & (sck_s != clock_polarity_select);
  assign sck_trail = sck_edge & (sck_s == clock_polarity_select);
  assign slave_active = spi_enable & ~master_select & (~four_wire | ~sel_filt);
  // sampling edge sits mid-bit; the other edge moves the outgoing bit
  assign slave_sample = slave_active & (clock_phase_select ? sck_trail : sck_lead);
  assign slave_shift = slave_active & (bit_cnt != '0)
    & (clock_phase_select ? sck_lead : sck_trail);

  // ----------------------------------------
  // master sequencer
  // ----------------------------------------
  scs_pkg::scs_master_state_type state, next_state;
  logic [7:0] div_cnt, next_div;
  logic half, next_half;
  logic master_sample, master_go, loaded;

  assign master_sample = (state == scs_pkg::M_RUN) & half & (div_cnt == HALF_END);
  assign master_go = spi_enable & master_select & loaded;

  always_comb begin
    next_state = state;
    next_div = div_cnt;
    next_half = half;
    unique case (state)
      scs_pkg::M_IDLE: begin
        if (master_go) begin
          next_state = scs_pkg::M_RUN;
          next_div = 8'h00;
          next_half = 1'b0;
        end
      end
      scs_pkg::M_RUN: begin
        if (div_cnt == HALF_END) begin
          next_div = 8'h00;
          next_half = ~half;
          if (master_sample && bit_cnt == LAST_BIT) begin
            next_state = scs_pkg::M_IDLE;
          end
        end else begin
          next_div = div_cnt + 8'h01;
        end
      end
    endcase
    if (!spi_enable || !master_select) begin
      next_state = scs_pkg::M_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= scs_pkg::M_IDLE;
      div_cnt <= 8'h00;
      half <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      div_cnt <= next_div;
      half <= next_half;
    end
  end

  // phase 1 opens each bit with an edge, phase 0 puts it mid-bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_out <= scs_pkg::POL_RST;
    end else if (clk_en) begin
      sck_out <= clock_polarity_select ^ ((next_state == scs_pkg::M_RUN)
        & (clock_phase_select ? ~next_half : next_half));
    end
  end

  // ----------------------------------------
  // bit counter and shifters
  // ----------------------------------------
  logic sample_now, byte_done_now, in_bit, load_now, rx_full, shifter_empty;
  logic [DATA_BITS-1:0] rx_shreg, tx_shreg, tx_buf;
  logic tx_full;

  assign sample_now = master_sample | slave_sample;
  assign byte_done_now = sample_now & (bit_cnt == LAST_BIT);
  assign in_bit = master_select ? miso_s : mosi_s;
  // mid-byte loads would corrupt the bit stream, so wait for a boundary
  assign load_now = tx_full & ((~loaded & (bit_cnt == '0)
    & (state == scs_pkg::M_IDLE)) | byte_done_now);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt <= '0;
    end else if (clk_en) begin
      if (!spi_enable || byte_done_now) begin
        bit_cnt <= '0;
      end else if (four_wire && !master_select && sel_fall) begin
        bit_cnt <= '0;
      end else if (sample_now) begin
        bit_cnt <= bit_cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_shreg <= '0;
    end else if (clk_en && sample_now) begin
      rx_shreg <= {rx_shreg[DATA_BITS-2:0], in_bit};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_shreg <= '0;
      loaded <= 1'b0;
    end else if (clk_en) begin
      if (load_now) begin
        tx_shreg <= tx_buf;
        loaded <= 1'b1;
      end else begin
        if (master_sample || slave_shift) begin
          tx_shreg <= {tx_shreg[DATA_BITS-2:0], 1'b0};
        end
        if (byte_done_now) begin
          loaded <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_buf <= '0;
      tx_full <= 1'b0;
    end else if (clk_en) begin
      if (tx_load && !tx_full) begin
        tx_buf <= tx_data;
        tx_full <= 1'b1;
      end else if (load_now) begin
        tx_full <= 1'b0;
      end
    end
  end

  // a slave overrun keeps the unread byte and drops the new one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_data <= '0;
      rx_full <= 1'b0;
      byte_done_flag <= 1'b0;
    end else if (clk_en) begin
      byte_done_flag <= byte_done_now;
      // a read in the same cycle frees the buffer, so the new byte wins
      if (byte_done_now && (master_select || !rx_full || rx_read)) begin
        rx_data <= {rx_shreg[DATA_BITS-2:0], in_bit};
        rx_full <= 1'b1;
      end else if (rx_read) begin
        rx_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // busy and shifter-empty status
  // ----------------------------------------
  // every byte starts on a leading edge in both phases
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slave_busy <= 1'b0;
    end else if (clk_en) begin
      if (!slave_active || byte_done_now || sel_fall) begin
        slave_busy <= 1'b0;
      end else if (sck_lead) begin
        slave_busy <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shifter_empty <= 1'b1;
    end else if (clk_en) begin
      if (load_now || (slave_active && sck_edge && (slave_busy || sck_lead)
          && !byte_done_now)) begin
        shifter_empty <= 1'b0;
      end else if (byte_done_now) begin
        shifter_empty <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register read and pin drive
  // ----------------------------------------
  logic busy_flag, shifter_empty_flag_view, rx_holding_empty_flag_view;

  assign busy_flag = (state == scs_pkg::M_RUN) | slave_busy;
  assign shifter_empty_flag_view = master_select | shifter_empty;
  assign rx_holding_empty_flag_view = master_select | ~rx_full;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata <= scs_pkg::UNMAPPED_DATA;
    end else if (clk_en && sfr_rd) begin
      if (cfg_hit) begin
        sfr_rdata <= {busy_flag, master_select, clock_phase_select,
          clock_polarity_select, ~sel_filt, sel_raw, shifter_empty_flag_view, rx_holding_empty_flag_view};
      end else begin
        sfr_rdata <= scs_pkg::UNMAPPED_DATA;
      end
    end
  end

  assign tx_empty = ~tx_full;
  assign sck_oe_n = ~(spi_enable & master_select);
  assign mosi_oe_n = ~(spi_enable & master_select);
  assign mosi_out = tx_shreg[DATA_BITS-1];
  assign miso_out = tx_shreg[DATA_BITS-1];
  assign miso_oe_n = ~slave_active;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);

  property p_busy_done;
    byte_done_flag |-> $past(busy_flag);
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("byte ended while not busy");

  property p_master_flags;
    master_select |-> shifter_empty_flag_view && rx_holding_empty_flag_view && !slave_active;
  endproperty
  a_master_flags: assert property (p_master_flags) else $error("master flags wrong");

  property p_filter;
    $changed(sel_filt) |-> $past(sel_raw, 1) == sel_filt && $past(sel_raw, 2) == sel_filt;
  endproperty
  a_filter: assert property (p_filter) else $error("select changed on a glitch");

  property p_sel_low;
    (!sel_raw)[*4] |-> !sel_filt;
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("selected flag not set");

  property p_rx_set;
    byte_done_now && (master_select || !rx_full) |=> rx_full && !rx_holding_empty_flag_view == !master_select;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive buffer not filled");

  property p_rx_read;
    rx_read && !byte_done_now |=> !rx_full;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive empty not set");

  property p_shifter_empty_flag_load;
    load_now |=> !shifter_empty && loaded;
  endproperty
  a_shifter_empty_flag_load: assert property (p_shifter_empty_flag_load) else $error("shifter empty after load");

  property p_cfg_write;
    sfr_wr && cfg_hit |=> master_select == $past(sfr_wdata[scs_pkg::BIT_MASTER])
      && clock_phase_select == $past(sfr_wdata[scs_pkg::BIT_PHASE])
      && clock_polarity_select == $past(sfr_wdata[scs_pkg::BIT_POL]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_sck_idle;
    // sck_out is registered, so it follows a polarity write one cycle late
    state == scs_pkg::M_IDLE ##1 state == scs_pkg::M_IDLE
      |-> sck_out == $past(clock_polarity_select);
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck not at idle level");

  property p_bit_reset;
    four_wire && !master_select && sel_fall && spi_enable |=> bit_cnt == '0;
  endproperty
  a_bit_reset: assert property (p_bit_reset) else $error("bit counter kept on select");

  c_master_byte: cover property (master_select && byte_done_now);
  c_slave_byte: cover property (!master_select && byte_done_now && clock_phase_select);
  c_overrun: cover property (!master_select && byte_done_now && rx_full);

endmodule

// [inc/scs_pkg.sv]
// Purpose: shared constants for the spi configuration/status block
// Assumes: 20 MHz system clock
// Notes: register bit positions, reset values and timing counts
package scs_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'ha1;
  localparam int BIT_BUSY = 7;
  localparam int BIT_MASTER = 6;
  localparam int BIT_PHASE = 5;
  localparam int BIT_POL = 4;
  localparam int BIT_SEL = 3;
  localparam int BIT_RAW = 2;
  localparam int BIT_SHIFTER_EMPTY_FLAG = 1;
  localparam int BIT_RX_HOLDING_EMPTY_FLAG = 0;
  localparam logic MASTER_RST = 1'b0;
  localparam logic PHASE_RST = 1'b0;
  localparam logic POL_RST = 1'b0;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCK_HALF_NS = 100;
  // longest time: round down, never below one cycle
  localparam int SCK_HALF_CYCLES =
    (SCK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : SCK_HALF_NS / CLK_PERIOD_NS;
  localparam int SELECT_FILTER_NS = 100;
  // least time: round up
  localparam int SELECT_FILTER_CYCLES =
    (SELECT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_BITS = 8;

  typedef enum logic {
    M_IDLE = 1'b0,
    M_RUN = 1'b1
  } scs_master_state_type;

endpackage

// [core/scs_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage feeds only the second stage
module scs_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clk_en) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [bench/scs_far_model.sv]
// Purpose: far-side model, an spi master or slave facing the block
// Assumes: link half period 200 ns, block master clock seen on sck_out
// Notes: released mosi shows the inverse of its last value, released miso does so only in phase 0
module scs_far_model (
  // pins driven by the block
  input wire logic sck_out,
  input wire logic mosi_out,
  input wire logic miso_out,
  // pins driven toward the block
  output logic sck_in,
  output logic mosi_in,
  output logic miso_in,
  output logic select_n_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic slv_on = 1'b0;
  logic [7:0] slv_tx;
  logic [7:0] slv_rx;
  int idx;
  initial begin
    sck_in = 1'b0;
    mosi_in = 1'b0;
    miso_in = 1'b0;
    select_n_in = 1'b1;
  end
  task automatic cfg(input logic pol, input logic pha);
    cpol = pol;
    cpha = pha;
    sck_in = pol;
    slv_on = 1'b0;
  endtask
  task automatic arm(input logic [7:0] b);
    slv_tx = b;
    slv_rx = 8'h00;
    idx = 0;
    miso_in = b[7];
    slv_on = 1'b1;
  endtask
  task automatic glitch();
    select_n_in = 1'b0;
    #50 select_n_in = 1'b1;
  endtask
  task automatic sel(input logic v);
    select_n_in = v;
  endtask
  // sck stands still outside frames
  task automatic xfer(input logic [7:0] tx, input int nbits, input logic use_sel,
                      output logic [7:0] rx);
    rx = 8'h00;
    select_n_in = ~use_sel;
    #400;
    for (int i = 0; i < nbits; i++) begin
      if (!cpha) mosi_in = tx[7-i];
      #200 sck_in = ~cpol;
      if (cpha) mosi_in = tx[7-i];
      else rx = {rx[6:0], miso_out};
      #200 sck_in = cpol;
      if (cpha) rx = {rx[6:0], miso_out};
    end
    #400 select_n_in = 1'b1;
    mosi_in = ~mosi_in;
    // gap lets the filter see the deselect before the next frame
    #400;
  endtask
  // slave role: sample on the data edge, shift on the other
  always @(sck_out) begin
    if (slv_on) begin
      if ((sck_out != cpol) ^ cpha) begin
        slv_rx = {slv_rx[6:0], mosi_out};
      end else begin
        if (cpha && idx < 8) miso_in = slv_tx[7-idx];
        idx++;
        if (!cpha) miso_in = (idx < 8) ? slv_tx[7-idx] : ~miso_in;
      end
    end
  end
endmodule

// [bench/test_spi_config_status_logic.sv]
// Purpose: self-checking bench for the spi configuration and status block
// Assumes: default half period and filter of two cycles
// Notes: each scenario is a task; inputs change 5 ns after the edge
module test_spi_config_status_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] sfr_addr = 8'ha1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic spi_enable = 1'b0;
  logic four_wire = 1'b1;
  logic tx_load = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_read = 1'b0;
  logic tx_empty, byte_done_flag;
  logic [7:0] rx_data;
  logic sck_in, sck_out, sck_oe_n, mosi_in, mosi_out, mosi_oe_n;
  logic miso_in, miso_out, miso_oe_n, select_n_in;
  int num_errors = 0;
  int comparisons = 0;
  int done_cnt = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (byte_done_flag === 1'b1) done_cnt <= done_cnt + 1;
  scs_core i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .spi_enable(spi_enable), .four_wire(four_wire), .tx_load(tx_load), .tx_data(tx_data),
    .rx_read(rx_read), .tx_empty(tx_empty), .rx_data(rx_data),
    .byte_done_flag(byte_done_flag), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .select_n_in(select_n_in));
  scs_far_model i_far (.sck_out(sck_out), .mosi_out(mosi_out), .miso_out(miso_out),
    .sck_in(sck_in), .mosi_in(mosi_in), .miso_in(miso_in), .select_n_in(select_n_in));
  // ----
  // bus and check helpers
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk) #5 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk) #5 sfr_rd = 1'b0;
    @(posedge clk) #5 d = sfr_rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reg();
    logic [7:0] d;
    rd(8'ha1, d); chk(d, 8'h07, "reset value");
    wr(8'ha1, 8'hff); rd(8'ha1, d); chk(d, 8'h77, "write all ones");
    wr(8'ha1, 8'h00); rd(8'ha1, d); chk(d, 8'h07, "write zeros");
    rd(8'h3c, d); chk(d, 8'h00, "unmapped read");
    wr(8'h3c, 8'h70); rd(8'ha1, d); chk(d, 8'h07, "other address write");
    clk_en = 1'b0;
    wr(8'ha1, 8'h70);
    clk_en = 1'b1;
    rd(8'ha1, d); chk(d, 8'h07, "write while frozen");
    $display("test reg done");
  endtask
  task automatic t_select();
    logic [7:0] d;
    i_far.glitch(); wait_cyc(6); rd(8'ha1, d); chk(d, 8'h07, "glitch filtered");
    i_far.sel(1'b0); wait_cyc(6); rd(8'ha1, d); chk(d, 8'h0b, "selected");
    i_far.sel(1'b1); wait_cyc(6); rd(8'ha1, d); chk(d, 8'h07, "deselected");
    $display("test select done");
  endtask
  task automatic t_slave(input logic pol, input logic pha, input logic [7:0] tx,
                         input logic [7:0] rxv);
    logic [7:0] d, got;
    int n;
    spi_enable = 1'b0;
    wr(8'ha1, {2'b00, pha, pol, 4'h0});
    i_far.cfg(pol, pha);
    spi_enable = 1'b1;
    tx_data = tx;
    tx_load = 1'b1;
    @(posedge clk) #5 tx_load = 1'b0;
    wait_cyc(3);
    n = done_cnt;
    fork
      i_far.xfer(rxv, 8, 1'b1, got);
      begin
        #1600 rd(8'ha1, d);
        chk(d & 8'h8a, 8'h88, "busy mid byte");
        chk({7'h0, miso_oe_n}, 8'h00, "slave drives miso");
      end
    join
    wait_cyc(4);
    chk(rx_data, rxv, "slave receive");
    chk(got, tx, "slave transmit");
    chk(8'(done_cnt - n), 8'h01, "byte done count");
    chk({7'h0, tx_empty}, 8'h01, "transmit buffer empty");
    rd(8'ha1, d); chk(d, {2'b00, pha, pol, 4'b0110}, "after byte");
    rx_read = 1'b1;
    @(posedge clk) #5 rx_read = 1'b0;
    rd(8'ha1, d); chk(d, {2'b00, pha, pol, 4'b0111}, "after read");
    $display("test slave mode %0d%0d done", pol, pha);
  endtask
  task automatic t_abort();
    logic [7:0] got;
    int n;
    n = done_cnt;
    i_far.xfer(8'h5a, 8, 1'b0, got);
    i_far.xfer(8'hff, 3, 1'b1, got);
    i_far.xfer(8'h96, 8, 1'b1, got);
    wait_cyc(4);
    chk(8'(done_cnt - n), 8'h01, "only selected byte counted");
    chk(rx_data, 8'h96, "counter restarted");
    rx_read = 1'b1;
    @(posedge clk) #5 rx_read = 1'b0;
    $display("test abort done");
  endtask
  task automatic t_master(input logic pol, input logic pha);
    logic [7:0] d;
    int n;
    spi_enable = 1'b0;
    wr(8'ha1, {2'b01, pha, pol, 4'h0});
    i_far.cfg(pol, pha);
    spi_enable = 1'b1;
    wait_cyc(3);
    chk({5'h0, miso_oe_n, sck_oe_n, mosi_oe_n}, 8'h04, "master drives pins");
    chk({7'h0, sck_out}, {7'h0, pol}, "idle clock level");
    i_far.arm(8'hc3);
    tx_data = 8'h5a;
    tx_load = 1'b1;
    @(posedge clk) #5 tx_load = 1'b0;
    wait_cyc(10);
    rd(8'ha1, d); chk(d & 8'h83, 8'h83, "master busy");
    n = 0;
    while (byte_done_flag !== 1'b1 && n < 200) begin
      wait_cyc(1);
      n++;
    end
    chk({7'h0, byte_done_flag}, 8'h01, "master byte done");
    wait_cyc(1);
    chk(rx_data, 8'hc3, "master receive");
    chk(i_far.slv_rx, 8'h5a, "master transmit");
    wait_cyc(4);
    chk({7'h0, sck_out}, {7'h0, pol}, "clock back idle");
    rd(8'ha1, d); chk(d, {2'b01, pha, pol, 4'b0111}, "master idle status");
    $display("test master mode %0d%0d done", pol, pha);
  endtask
  initial begin
    #500000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    wait_cyc(6);
    sys_rst = 1'b0;
    t_reg();
    spi_enable = 1'b1;
    t_select();
    for (int m = 0; m < 4; m++) begin
      t_slave(m[1], m[0], 8'(8'ha5 + m), 8'(8'h3c ^ m));
    end
    spi_enable = 1'b0;
    wr(8'ha1, 8'h00);
    i_far.cfg(1'b0, 1'b0);
    spi_enable = 1'b1;
    t_abort();
    t_master(1'b0, 1'b0);
    t_master(1'b1, 1'b1);
    end_sim();
  end
endmodule
